// ==== hw/pct_timer_map.vh ====
// Purpose: Register map and field constants of the PWM/capture timer control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Included by hw/pct_timer_ctrl.v
// What this block does
// - PWM mode: run bit set starts counter from zero, clear stops and reloads
// - PWM stop waits for cycle end; run bit shows real stop
// - Capture mode: run bit is overflow flag, set on wrap from all-ones
// - PWM mode: pending flag set when counter rolls from period to zero
// - Capture mode: pending flag set on capture at selected pin edge
// - Bit 2 enables the timer interrupt from the pending flags
// - PWM irq from pending only; capture irq is pending OR overflow
// - Interrupt stays asserted while any enabled flag remains set
// - Writing 1 holds a flag, writing 0 clears it, never sets
// - Attribute bit applies from next PWM cycle while running, at once when idle or in capture mode; read returns written value
`ifndef PCT_TIMER_MAP_VH
`define PCT_TIMER_MAP_VH

// Byte offsets
`define PCT_OFF_CTRL 8'h00
`define PCT_OFF_PERIOD 8'h04
`define PCT_OFF_COUNT 8'h08
`define PCT_OFF_CAPT 8'h0C
`define PCT_OFF_EVT 8'h10
`define PCT_OFF_MASK 8'h14
`define PCT_OFF_DUTY 8'h18

// Control register fields
`define PCT_B_MODE 7
`define PCT_B_EDGE 6
`define PCT_B_ATTR 5
`define PCT_B_RUN 4
`define PCT_B_PND 3
`define PCT_B_IEN 2
`define PCT_CTRL_W 8

// Counter width and values
`define PCT_CNT_W 12
`define PCT_CNT_ZERO 12'h000
`define PCT_CNT_ONES 12'hFFF
`define PCT_CNT_ONE 12'h001

// Event status fields
`define PCT_EVT_W 4
`define PCT_E_WRAP 0
`define PCT_E_CAPT 1
`define PCT_E_OVF 2
`define PCT_E_STOP 3

// Reset values
`define PCT_RST_PERIOD 12'hFFF
`define PCT_RST_DUTY 12'h800
`define PCT_RST_EVT 4'h0

`endif

// ==== hw/pct_pin_sync.v ====
// Purpose: Bring the capture pin into the clock domain and report its edges
// Assumes: Pin is asynchronous to clock
// Notes: A change counts once the second and third stages agree

module pct_pin_sync (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Pin side
  input wire pin,
  // Edge pulses
  output reg rise,
  output reg fall
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  reg level_reg;

  // Three stage chain; only s2 reads s1
  always @(posedge clock) begin
    if (!resetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Filtered level and edge pulses, glitches shorter than a cycle are dropped
  always @(posedge clock) begin
    if (!resetn) begin
      level_reg <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != level_reg) begin
        level_reg <= s3_reg;
        rise <= s3_reg;
        fall <= ~s3_reg;
      end
    end
  end

endmodule

// ==== hw/pct_timer_ctrl.v ====
// Purpose: Control and status of a 12-bit PWM and input-capture timer
// Assumes: Single clock; timer clock is a tick enable from a divider
// Notes: APB slave, zero wait states, unmapped addresses answer pslverr;
//   flags clear on a written zero, so a read-modify-write of the control
//   byte can wipe a flag that hardware set in between
//
// The APB register port and the register addresses were chosen for this implementation.

`include "pct_timer_map.vh"

module pct_timer_ctrl #(
  parameter TICK_DIV = 16'd1,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Timer pins
  input wire capture_input_pin,
  output reg pwm_out,
  // Interrupts
  output wire timer_irq,
  output wire evt_irq
);

  // Control fields
  reg cap_mode_reg;
  reg edge_fall_reg;
  reg attr_sw_reg;
  reg attr_act_reg;
  reg run_reg;
  reg stop_req_reg;
  reg ovf_reg;
  reg pnd_reg;
  reg ien_reg;
  // Timer data
  reg [`PCT_CNT_W-1:0] cnt_reg;
  reg [`PCT_CNT_W-1:0] period_reg;
  reg [`PCT_CNT_W-1:0] duty_reg;
  reg [`PCT_CNT_W-1:0] capt_reg;
  reg [15:0] div_reg;
  // Event status and mask
  reg [`PCT_EVT_W-1:0] evt_reg;
  reg [`PCT_EVT_W-1:0] mask_reg;
  reg [`PCT_EVT_W-1:0] evt_rd_reg;
  reg evt_rd_hit_reg;

  wire tick;
  wire cap_rise;
  wire cap_fall;
  wire cap_edge;
  // Decoded bus strobes
  wire setup_ph;
  wire wr_acc;
  wire rd_acc;
  wire hit;
  wire wr_ctrl;
  wire wr_period;
  wire wr_duty;
  wire wr_mask;
  wire [7:0] wbyte;
  // Timer events and flag strobes
  wire pwm_wrap;
  wire cap_wrap;
  wire cap_hit;
  wire stop_done;
  wire pnd_clr;
  wire ovf_clr;
  wire [`PCT_EVT_W-1:0] evt_set;
  wire [`PCT_CTRL_W-1:0] ctrl_view;
  reg [31:0] rd_next;

  // Capture pin synchroniser and edge finder
  pct_pin_sync u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin(capture_input_pin),
    .rise(cap_rise),
    .fall(cap_fall)
  );

  // Selected capture edge
  assign cap_edge = edge_fall_reg ? cap_fall : cap_rise;

  // Timer clock divider; tick is a one-cycle enable
  // A divider of one ticks on every clock
  assign tick = (div_reg == TICK_DIV - 16'd1);

  always @(posedge clock) begin
    if (!resetn) begin
      div_reg <= 16'h0000;
    end else if (tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'd1;
    end
  end

  // APB phases; zero wait states so every access ends at once
  // Offsets outside the map raise pslverr and writes there are dropped
  assign setup_ph = psel & ~penable;
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign hit = (paddr == `PCT_OFF_CTRL) || (paddr == `PCT_OFF_PERIOD) ||
               (paddr == `PCT_OFF_COUNT) || (paddr == `PCT_OFF_CAPT) ||
               (paddr == `PCT_OFF_EVT) || (paddr == `PCT_OFF_MASK) ||
               (paddr == `PCT_OFF_DUTY);
  assign pslverr = psel & penable & ~hit;
  assign wr_ctrl = wr_acc & pstrb[0] & (paddr == `PCT_OFF_CTRL);
  assign wbyte = pwdata[7:0];

  // Per-register write strobes; period and duty also take lane 1
  assign wr_period = wr_acc & (paddr == `PCT_OFF_PERIOD);
  assign wr_duty = wr_acc & (paddr == `PCT_OFF_DUTY);
  assign wr_mask = wr_acc & pstrb[0] & (paddr == `PCT_OFF_MASK);

  // Counter wrap events in each mode
  assign pwm_wrap = ~cap_mode_reg & run_reg & tick & (cnt_reg == period_reg);
  assign cap_wrap = cap_mode_reg & tick & (cnt_reg == `PCT_CNT_ONES);
  assign cap_hit = cap_mode_reg & cap_edge;
  // A stop request completes only at the end of the running cycle
  assign stop_done = pwm_wrap & stop_req_reg;

  // Flag strobes; a write can only clear, the hardware events set
  assign pnd_clr = wr_ctrl & ~wbyte[`PCT_B_PND];
  assign ovf_clr = wr_ctrl & cap_mode_reg & ~wbyte[`PCT_B_RUN];

  // Event vector for the sticky status word
  assign evt_set[`PCT_E_WRAP] = pwm_wrap;
  assign evt_set[`PCT_E_CAPT] = cap_hit;
  assign evt_set[`PCT_E_OVF] = cap_wrap;
  assign evt_set[`PCT_E_STOP] = stop_done;

  // Readback of the control byte; bit 4 follows the mode
  assign ctrl_view = {cap_mode_reg, edge_fall_reg, attr_sw_reg,
                      cap_mode_reg ? ovf_reg : run_reg,
                      pnd_reg, ien_reg, 2'b00};

  assign timer_irq = ien_reg & (pnd_reg | (cap_mode_reg & ovf_reg));

  // Event interrupt, high while an unmasked sticky bit is set
  assign evt_irq = |(evt_reg & mask_reg);

  // Configuration words, written by software and read back
  always @(posedge clock) begin
    if (!resetn) begin
      period_reg <= `PCT_RST_PERIOD;
      duty_reg <= `PCT_RST_DUTY;
      mask_reg <= `PCT_RST_EVT;
      cap_mode_reg <= 1'b0;
      edge_fall_reg <= 1'b0;
      attr_sw_reg <= 1'b0;
      ien_reg <= 1'b0;
    end else begin
      // Only whole lanes are taken; lane 1 holds the top bits
      if (wr_period) begin
        if (pstrb[0])
          period_reg[7:0] <= pwdata[7:0];
        if (pstrb[1])
          period_reg[11:8] <= pwdata[11:8];
      end
      if (wr_duty) begin
        if (pstrb[0])
          duty_reg[7:0] <= pwdata[7:0];
        if (pstrb[1])
          duty_reg[11:8] <= pwdata[11:8];
      end
      if (wr_mask)
        mask_reg <= pwdata[`PCT_EVT_W-1:0];
      if (wr_ctrl) begin
        cap_mode_reg <= wbyte[`PCT_B_MODE];
        edge_fall_reg <= wbyte[`PCT_B_EDGE];
        attr_sw_reg <= wbyte[`PCT_B_ATTR];
        ien_reg <= wbyte[`PCT_B_IEN];
      end
    end
  end

  // Run bit and deferred stop in PWM mode
  // Run reads 1 until the stop lands, so software can poll it
  always @(posedge clock) begin
    if (!resetn) begin
      run_reg <= 1'b0;
      stop_req_reg <= 1'b0;
    end else if (cap_mode_reg) begin
      // Capture mode has no run control; keep PWM state idle
      run_reg <= 1'b0;
      stop_req_reg <= 1'b0;
    end else begin
      if (stop_done) begin
        run_reg <= 1'b0;
        stop_req_reg <= 1'b0;
      end
      if (wr_ctrl && wbyte[`PCT_B_RUN]) begin
        run_reg <= 1'b1;
        stop_req_reg <= 1'b0;
      end else if (wr_ctrl && run_reg && !stop_done) begin
        stop_req_reg <= 1'b1;
      end
    end
  end

  // Timer counter
  // Entering capture does not clear it, so capture counts on from its value
  always @(posedge clock) begin
    if (!resetn) begin
      cnt_reg <= `PCT_CNT_ZERO;
    end else if (cap_mode_reg) begin
      if (tick)
        cnt_reg <= cnt_reg + `PCT_CNT_ONE;
    end else if (!run_reg) begin
      cnt_reg <= `PCT_CNT_ZERO;
    end else if (tick) begin
      if (cnt_reg == period_reg)
        cnt_reg <= `PCT_CNT_ZERO;
      else
        cnt_reg <= cnt_reg + `PCT_CNT_ONE;
    end
  end

  // Captured value
  always @(posedge clock) begin
    if (!resetn) begin
      capt_reg <= `PCT_CNT_ZERO;
    end else if (cap_hit) begin
      capt_reg <= cnt_reg;
    end
  end

  // Pending and overflow flags; the set wins over a clearing write
  always @(posedge clock) begin
    if (!resetn) begin
      pnd_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if (pnd_clr)
        pnd_reg <= 1'b0;
      if (ovf_clr)
        ovf_reg <= 1'b0;
      if (pwm_wrap)
        pnd_reg <= 1'b1;
      if (cap_hit)
        pnd_reg <= 1'b1;
      if (cap_wrap)
        ovf_reg <= 1'b1;
    end
  end

  // Changing the sense mid-cycle would cut a pulse short
  // attribute taken at cycle end
  always @(posedge clock) begin
    if (!resetn) begin
      attr_act_reg <= 1'b0;
    end else if (cap_mode_reg || !run_reg || pwm_wrap) begin
      // Idle timer has no cycle to protect, so take it at once
      attr_act_reg <= attr_sw_reg;
    end
  end

  // PWM output; the attribute inverts the sense
  // Duty above the period keeps the output on all cycle
  always @(posedge clock) begin
    if (!resetn) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= ((~cap_mode_reg & run_reg) & (cnt_reg < duty_reg)) ^ attr_act_reg;
    end
  end

  // Sticky event bits; a read clears only what it returned
  // An event in the clearing cycle survives, since it was not returned
  always @(posedge clock) begin
    if (!resetn) begin
      evt_reg <= `PCT_RST_EVT;
    end else begin
      if (rd_acc && evt_rd_hit_reg)
        evt_reg <= (evt_reg & ~evt_rd_reg) | evt_set;
      else
        evt_reg <= evt_reg | evt_set;
    end
  end

  // Read data multiplexer
  // Unused upper bits and unmapped offsets read zero
  always @* begin
    rd_next = 32'h0000_0000;
    case (paddr)
      `PCT_OFF_CTRL:
        rd_next[`PCT_CTRL_W-1:0] = ctrl_view;
      `PCT_OFF_PERIOD:
        rd_next[`PCT_CNT_W-1:0] = period_reg;
      `PCT_OFF_COUNT:
        rd_next[`PCT_CNT_W-1:0] = cnt_reg;
      `PCT_OFF_CAPT:
        rd_next[`PCT_CNT_W-1:0] = capt_reg;
      `PCT_OFF_EVT:
        rd_next[`PCT_EVT_W-1:0] = evt_reg;
      `PCT_OFF_MASK:
        rd_next[`PCT_EVT_W-1:0] = mask_reg;
      `PCT_OFF_DUTY:
        rd_next[`PCT_CNT_W-1:0] = duty_reg;
      default:
        rd_next = 32'h0000_0000;
    endcase
  end

  // Read data sampled in the setup phase, held through access
  // Loading at setup keeps prdata steady through any access length
  always @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
      evt_rd_reg <= `PCT_RST_EVT;
      evt_rd_hit_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata <= rd_next;
      evt_rd_reg <= evt_reg;
      evt_rd_hit_reg <= ~pwrite & (paddr == `PCT_OFF_EVT);
    end
  end

endmodule

// ==== verif/pct_timer_props.sv ====
// Purpose: Port-level checks of the timer control block
// Assumes: Zero-wait APB slave, map ends at 0x18
// Notes: Bound to every pct_timer_ctrl instance
module pct_timer_props #(
  parameter TICK_DIV = 16'd1,
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Timer outputs
  input wire pwm_out,
  input wire timer_irq,
  input wire evt_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Access phase decode
  wire acc = psel && penable;
  wire wr_ctrl = acc && pwrite && paddr == 8'h00;
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_in_access: assert property (pslverr |-> acc) else $error("pslverr outside access");
  a_err_unmapped: assert property (acc && paddr > 8'h18 |-> pslverr) else $error("no error on hole");
  a_err_mapped: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped word");
  a_read_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0) else $error("hole reads nonzero");
  // Reset itself must be checked, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !timer_irq && !evt_irq && !pwm_out)
    else $error("outputs active after reset");
  a_ien_gates_irq: assert property (wr_ctrl && !pwdata[2] |=> !timer_irq [*2]) else $error("irq without enable");
  a_capt_attr_now: assert property (wr_ctrl && pwdata[7] && !pwdata[5] |=> ##2 !pwm_out)
    else $error("capture attribute not applied");
  a_mask_off: assert property (acc && pwrite && paddr == 8'h14 && pwdata[3:0] == 4'h0 |=> !evt_irq)
    else $error("evt_irq with mask clear");
endmodule

bind pct_timer_ctrl pct_timer_props #(.TICK_DIV(TICK_DIV), .ADDR_W(ADDR_W)) u_props (.clock(clock),
  .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .timer_irq(timer_irq),
  .evt_irq(evt_irq));

// ==== verif/pwm_capture_timer_control_bench.sv ====
// Purpose: Directed bench of the timer control block
// Assumes: One tick per clock, zero-wait APB
// Notes: Period kept short so wraps come fast
module pwm_capture_timer_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, cap = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r, v;
  wire [31:0] prdata;
  wire pready, pslverr, pwm_out, timer_irq, evt_irq;
  int n_fail = 0, n_checks = 0;
  // Clock at 200 MHz
  always #2.5 clock = ~clock;
  pct_timer_ctrl DUT (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_pin(cap), .pwm_out(pwm_out), .timer_irq(timer_irq), .evt_irq(evt_irq));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; waits on pready, takes data at that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Read control until a bit reaches a value, bounded; no read at all if the last read data already has it
  task poll(input int b, input logic x);
    for (int i = 0; i < 3000 && r[b] !== x; i++) apb(0, 8'h00, 0);
  endtask
  task t_reset;
    apb(0, 8'h00, 0);
    chk("ctrl", r, 32'h0);
    apb(0, 8'h04, 0);
    chk("period", r, 32'hFFF);
    apb(0, 8'h18, 0);
    chk("duty", r, 32'h800);
    apb(0, 8'h1C, 0);
    chk("hole_err", e, 1);
    $display("TB: reset test done");
  endtask
  task t_pwm;
    apb(1, 8'h04, 32'h40);
    apb(1, 8'h14, 32'h1);
    apb(1, 8'h00, 32'h14);
    apb(0, 8'h08, 0);
    v = r;
    apb(0, 8'h08, 0);
    chk("count_up", r[11:0] > v[11:0] && v[11:0] < 12'h008, 1);
    poll(3, 1);
    chk("pending", r[3], 1);
    chk("timer_irq", timer_irq, 1);
    chk("evt_irq", evt_irq, 1);
    apb(1, 8'h00, 32'h18);
    apb(0, 8'h00, 0);
    chk("pnd_hold", r[3], 1);
    chk("irq_ien_off", timer_irq, 0);
    apb(1, 8'h14, 32'h0);
    apb(0, 8'h10, 0);
    chk("evt_wrap", r[0], 1);
    apb(0, 8'h10, 0);
    chk("evt_cleared", r[0], 0);
    apb(1, 8'h00, 32'h14);
    apb(0, 8'h00, 0);
    chk("pnd_clear", r[3], 0);
    poll(3, 1);
    apb(1, 8'h00, 32'h34);
    chk("attr_deferred", pwm_out, 1);
    apb(0, 8'h00, 0);
    chk("attr_read", r[5], 1);
    chk("attr_held", pwm_out, 1);
    poll(3, 1);
    chk("attr_applied", pwm_out, 0);
    apb(1, 8'h00, 32'h20);
    apb(0, 8'h00, 0);
    chk("stop_deferred", r[4], 1);
    poll(4, 0);
    chk("stopped", r[4], 0);
    apb(0, 8'h08, 0);
    chk("count_zero", r, 32'h0);
    $display("TB: pwm test done");
  endtask
  task t_capture;
    apb(1, 8'h00, 32'h84);
    cap <= 1;
    repeat (8) @(posedge clock);
    apb(0, 8'h00, 0);
    chk("capt_rise", r[3], 1);
    chk("irq_capt", timer_irq, 1);
    apb(0, 8'h0C, 0);
    chk("capt_value", r[11:0] >= 12'h003 && r[11:0] <= 12'h006, 1);
    apb(1, 8'h00, 32'hC4);
    cap <= 0;
    repeat (8) @(posedge clock);
    apb(0, 8'h00, 0);
    chk("capt_fall", r[3], 1);
    apb(1, 8'h00, 32'h84);
    cap <= 1;
    repeat (8) @(posedge clock);
    cap <= 0;
    repeat (8) @(posedge clock);
    apb(1, 8'h00, 32'h84);
    poll(4, 1);
    chk("ovf", r[4:3], 2'b10);
    chk("irq_ovf", timer_irq, 1);
    apb(1, 8'h00, 32'h94);
    apb(0, 8'h00, 0);
    chk("ovf_hold", r[4], 1);
    apb(1, 8'h00, 32'h84);
    apb(0, 8'h00, 0);
    chk("ovf_clear", r[4], 0);
    chk("irq_drop", timer_irq, 0);
    chk("evt_irq_masked", evt_irq, 0);
    apb(0, 8'h10, 0);
    chk("evt_all", r, 32'hF);
    $display("TB: capture test done");
  endtask
  task finish_test;
    $display("TB: %0d checks, %0d mismatches", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1;
    t_reset;
    t_pwm;
    t_capture;
    finish_test;
  end
  // Watchdog, well past the 4096-tick overflow wait
  initial begin
    repeat (40000) @(posedge clock);
    n_fail++;
    finish_test;
  end
endmodule
